/* hw/sas_params.svh */
`ifndef SAS_PARAMS_SVH
`define SAS_PARAMS_SVH
// ****************************************
// register indices
// ****************************************
`define SAS_ADDR_CON1 4'h0
`define SAS_ADDR_CON2 4'h1
`define SAS_ADDR_CON4 4'h2
`define SAS_ADDR_STAT 4'h3
`define SAS_ADDR_MASK 4'h4
`define SAS_ADDR_CHS0 4'h5
`define SAS_ADDR_RES 4'h6
// ****************************************
// control one fields
// ****************************************
`define SAS_C1_ON 15
`define SAS_C1_DMAORD 12
`define SAS_C1_RES12 10
`define SAS_C1_FORM_LO 8
`define SAS_C1_TRIG_LO 5
`define SAS_C1_PAR 3
`define SAS_C1_AUTO 2
`define SAS_C1_ACQ 1
`define SAS_C1_DONE 0
`define SAS_C1_WMASK 16'h97EC
// ****************************************
// control two fields
// ****************************************
`define SAS_C2_CHPS_LO 8
`define SAS_C2_SMPI_LO 2
`define SAS_C2_WMASK 16'hE73F
// ****************************************
// codes and timing
// ****************************************
`define SAS_TRIG_SW 3'h0
`define SAS_TRIG_TMR_A 3'h2
`define SAS_TRIG_TMR_B 3'h4
`define SAS_TRIG_AUTO 3'h7
`define SAS_FORM_SFRAC 2'h3
`define SAS_FORM_UFRAC 2'h2
`define SAS_FORM_SINT 2'h1
`define SAS_NUM_INPUTS 13
`define SAS_LAST_INPUT 4'hC
`define SAS_SAMPLE_NS 200
`define SAS_CLK_NS 20
`define SAS_SAMPLE_CYC ((`SAS_SAMPLE_NS + `SAS_CLK_NS - 1) / `SAS_CLK_NS)
`define SAS_CONV10_CYC 5'hC
`define SAS_CONV12_CYC 5'hE
`define SAS_IRQ_DONE 0
`endif

/* hw/sas_pkg.sv */
package sas_pkg;
   typedef enum logic [1:0] {
      SAS_IDLE = 2'b00,
      SAS_SAMPLE = 2'b01,
      SAS_CONVERT = 2'b10
   } sas_state_type;
   typedef struct packed {
      logic valid;
      logic [10:0] addr;
      logic [15:0] data;
   } sas_dma_type;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [15:0] wdata;
   } sas_bus_type;
endpackage

/* hw/sas_result_mem.sv */
`timescale 1ns/1ps
// ****************************************
// standalone result store, registered read
// ****************************************
module sas_result_mem (
   input wire logic core_clk_in,
   input wire logic wr_in,
   input wire logic [3:0] waddr_in,
   input wire logic [15:0] wdata_in,
   input wire logic [3:0] raddr_in,
   output logic [15:0] rdata_out
);
   logic [15:0] mem [0:15];
   always_ff @(posedge core_clk_in) begin
      if (wr_in) begin
         mem[waddr_in] <= wdata_in;
      end
   end
   always_ff @(posedge core_clk_in) begin
      rdata_out <= mem[raddr_in];
   end
endmodule

/* hw/sas_sequencer.sv */
`timescale 1ns/1ps
`include "sas_params.svh"
module sas_sequencer (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic [3:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic timer_a_event_in,
   input wire logic timer_b_event_in,
   input wire logic [11:0] analog_result_in,
   input wire logic dma_ack_in,
   output logic [15:0] rdata_out,
   output logic irq_out,
   output logic sample_out,
   output logic [3:0] hold_enable_out,
   output logic [3:0] input_select_out,
   output logic convert_out,
   output sas_pkg::sas_dma_type dma_out
);
   // ****************************************
   // registers
   // ****************************************
   logic [15:0] con1;
   logic [15:0] con2;
   logic [2:0] dma_buf_len;
   logic [4:0] input_sel;
   logic irq_status;
   logic irq_mask;
   sas_pkg::sas_state_type state;
   logic [4:0] timer;
   logic [1:0] chan;
   logic [3:0] op_count;
   logic [3:0] buf_ptr;
   logic [6:0] per_input_ptr [0:3];
   logic rd_q;
   logic [3:0] rd_addr_q;
   logic [15:0] mem_rdata;
   logic mem_wr;
   logic [15:0] formatted;
   logic conv_end;
   logic conv_start;
   logic last_chan;
   logic trigger;
   logic [1:0] chans;
   logic [3:0] cur_input;
   logic next_acq;
   logic sw_acq_set;
   logic sw_acq_clr;
   logic wr_c1;

   wire logic res12 = con1[`SAS_C1_RES12];
   wire logic [2:0] trig_sel = con1[`SAS_C1_TRIG_LO +: 3];
   wire logic [1:0] form_sel = con1[`SAS_C1_FORM_LO +: 2];
   wire logic [3:0] smpi = con2[`SAS_C2_SMPI_LO +: 4];
   wire logic conv_on = con1[`SAS_C1_ON];
   // parallel hold unavailable in 12-bit
   wire logic par_hold = con1[`SAS_C1_PAR] & ~res12;

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [15:0] fmt(input logic [11:0] raw,
         input logic [1:0] form, input logic r12);
      logic [15:0] v;
      v = 16'h0000;
      if (r12) begin
         case (form)
            `SAS_FORM_SFRAC: v = {~raw[11], raw[10:0], 4'h0};
            `SAS_FORM_UFRAC: v = {raw, 4'h0};
            `SAS_FORM_SINT: v = {{5{~raw[11]}}, raw[10:0]};
            default: v = {4'h0, raw};
         endcase
      end else begin
         case (form)
            `SAS_FORM_SFRAC: v = {~raw[9], raw[8:0], 6'h00};
            `SAS_FORM_UFRAC: v = {raw[9:0], 6'h00};
            `SAS_FORM_SINT: v = {{7{~raw[9]}}, raw[8:0]};
            default: v = {6'h00, raw[9:0]};
         endcase
      end
      return v;
   endfunction

   function automatic logic [1:0] chan_count(input logic [1:0] chps,
         input logic r12);
      logic [1:0] n;
      n = 2'h0;
      if (!r12) begin
         if (chps[1]) begin
            n = 2'h3;
         end else if (chps[0]) begin
            n = 2'h1;
         end
      end
      return n;
   endfunction

   // ****************************************
   // decode
   // ****************************************
   always_comb begin
      chans = chan_count(con2[`SAS_C2_CHPS_LO +: 2], res12);
      last_chan = (chan == chans) | par_hold;
      cur_input = (chan == 2'h0) ?
         ((input_sel[3:0] > `SAS_LAST_INPUT) ? `SAS_LAST_INPUT
          : input_sel[3:0]) : {2'h0, chan};
      case (trig_sel)
         `SAS_TRIG_AUTO: trigger = (timer == 5'h00);
         `SAS_TRIG_TMR_B: trigger = timer_b_event_in;
         `SAS_TRIG_TMR_A: trigger = timer_a_event_in;
         default: trigger = 1'b0;
      endcase
      wr_c1 = wr_in && (addr_in == `SAS_ADDR_CON1);
      sw_acq_set = wr_c1 && wdata_in[`SAS_C1_ACQ] &&
         !con1[`SAS_C1_AUTO];
      sw_acq_clr = wr_c1 && !wdata_in[`SAS_C1_ACQ] &&
         (trig_sel == `SAS_TRIG_SW);
      conv_start = (state == sas_pkg::SAS_SAMPLE) &&
         (sw_acq_clr || ((trig_sel != `SAS_TRIG_SW) && trigger));
      conv_end = (state == sas_pkg::SAS_CONVERT) && (timer == 5'h00);
      formatted = fmt(analog_result_in, form_sel, res12);
      mem_wr = conv_end;
   end

   // ****************************************
   // sequencer
   // ****************************************
   always_ff @(posedge core_clk_in) begin
      if (rst_in || !conv_on) begin
         state <= sas_pkg::SAS_IDLE;
         timer <= 5'h00;
         chan <= 2'h0;
      end else begin
         case (state)
            sas_pkg::SAS_IDLE: begin
               if (con1[`SAS_C1_AUTO] || sw_acq_set) begin
                  state <= sas_pkg::SAS_SAMPLE;
                  timer <= 5'(`SAS_SAMPLE_CYC);
               end
            end
            sas_pkg::SAS_SAMPLE: begin
               if (timer != 5'h00) begin
                  timer <= timer - 5'h01;
               end
               if (conv_start) begin
                  state <= sas_pkg::SAS_CONVERT;
                  timer <= res12 ? `SAS_CONV12_CYC : `SAS_CONV10_CYC;
               end
            end
            sas_pkg::SAS_CONVERT: begin
               if (timer != 5'h00) begin
                  timer <= timer - 5'h01;
               end else if (!last_chan) begin
                  // sequential channels convert one after another
                  chan <= chan + 2'h1;
                  timer <= res12 ? `SAS_CONV12_CYC : `SAS_CONV10_CYC;
               end else begin
                  chan <= 2'h0;
                  if (con1[`SAS_C1_AUTO]) begin
                     state <= sas_pkg::SAS_SAMPLE;
                     timer <= 5'(`SAS_SAMPLE_CYC);
                  end else begin
                     state <= sas_pkg::SAS_IDLE;
                  end
               end
            end
            default: state <= sas_pkg::SAS_IDLE;
         endcase
      end
   end

   // ****************************************
   // control registers
   // ****************************************
   always_comb begin
      next_acq = con1[`SAS_C1_ACQ];
      if (sw_acq_set || (conv_end && last_chan && con1[`SAS_C1_AUTO]))
      begin
         next_acq = 1'b1;
      end
      if (conv_start) begin
         next_acq = 1'b0;
      end
      if (!conv_on) begin
         next_acq = 1'b0;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         con1 <= 16'h0000;
      end else begin
         if (wr_c1) begin
            con1 <= (wdata_in & `SAS_C1_WMASK) |
               (con1 & ~`SAS_C1_WMASK & 16'h0001);
            // software may only clear done
            con1[`SAS_C1_DONE] <= con1[`SAS_C1_DONE] &
               wdata_in[`SAS_C1_DONE];
         end
         con1[`SAS_C1_ACQ] <= next_acq;
         if (conv_start) begin
            con1[`SAS_C1_DONE] <= 1'b0;
         end
         if (conv_end && last_chan) begin
            con1[`SAS_C1_DONE] <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         con2 <= 16'h0000;
         dma_buf_len <= 3'h0;
         input_sel <= 5'h00;
         irq_mask <= 1'b0;
      end else if (wr_in) begin
         case (addr_in)
            `SAS_ADDR_CON2: con2 <= wdata_in & `SAS_C2_WMASK;
            `SAS_ADDR_CON4: dma_buf_len <= wdata_in[2:0];
            `SAS_ADDR_CHS0: input_sel <= wdata_in[4:0];
            `SAS_ADDR_MASK: irq_mask <= wdata_in[`SAS_IRQ_DONE];
            default: ;
         endcase
      end
   end

   // ****************************************
   // sequence counting, flag, dma
   // ****************************************
   wire logic seq_done = conv_end && last_chan;
   wire logic count_hit = seq_done && (op_count == smpi);

   always_ff @(posedge core_clk_in) begin
      if (rst_in || !conv_on) begin
         op_count <= 4'h0;
      end else if (seq_done) begin
         op_count <= count_hit ? 4'h0 : op_count + 4'h1;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         irq_status <= 1'b0;
      end else if (count_hit) begin
         irq_status <= 1'b1;
      end else if (wr_in && addr_in == `SAS_ADDR_STAT &&
            wdata_in[`SAS_IRQ_DONE]) begin
         irq_status <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in || !conv_on) begin
         buf_ptr <= 4'h0;
         for (int i = 0; i < 4; i++) begin
            per_input_ptr[i] <= 7'h00;
         end
      end else if (mem_wr) begin
         buf_ptr <= buf_ptr + 4'h1;
         per_input_ptr[chan] <= (per_input_ptr[chan] + 7'h01) &
            7'((8'h01 << dma_buf_len) - 8'h01);
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         dma_out <= '0;
      end else if (mem_wr) begin
         dma_out.valid <= count_hit;
         dma_out.data <= formatted;
         if (con1[`SAS_C1_DMAORD]) begin
            dma_out.addr <= {7'h00, buf_ptr};
         end else begin
            dma_out.addr <= 11'(({7'h00, cur_input} << dma_buf_len) +
               {4'h0, per_input_ptr[chan]});
         end
      end else if (dma_ack_in) begin
         dma_out.valid <= 1'b0;
      end
   end

   sas_result_mem u_mem (
      .core_clk_in(core_clk_in),
      .wr_in(mem_wr),
      .waddr_in(buf_ptr),
      .wdata_in(formatted),
      .raddr_in(addr_in),
      .rdata_out(mem_rdata)
   );

   // ****************************************
   // outputs and read port
   // ****************************************
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         irq_out <= 1'b0;
         sample_out <= 1'b0;
         hold_enable_out <= 4'h0;
         input_select_out <= 4'h0;
         convert_out <= 1'b0;
      end else begin
         irq_out <= irq_status & irq_mask;
         sample_out <= (state == sas_pkg::SAS_SAMPLE);
         hold_enable_out <= par_hold ?
            4'(({1'b0, chans} + 3'h1 == 3'h4) ? 4'hF : 4'h3) :
            4'(4'h1 << chan);
         input_select_out <= cur_input;
         convert_out <= (state == sas_pkg::SAS_CONVERT);
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         rd_q <= 1'b0;
         rd_addr_q <= 4'h0;
      end else begin
         rd_q <= rd_in;
         rd_addr_q <= addr_in;
      end
   end

   always_comb begin
      case (rd_addr_q)
         `SAS_ADDR_CON1: rdata_out = {con1[15:4], par_hold,
            con1[2:0]};
         `SAS_ADDR_CON2: rdata_out = res12 ?
            (con2 & 16'hFCFF) : con2;
         `SAS_ADDR_CON4: rdata_out = {13'h0000, dma_buf_len};
         `SAS_ADDR_STAT: rdata_out = {15'h0000, irq_status};
         `SAS_ADDR_MASK: rdata_out = {15'h0000, irq_mask};
         `SAS_ADDR_CHS0: rdata_out = {11'h000, input_sel};
         default: rdata_out = mem_rdata;
      endcase
      if (!rd_q) begin
         rdata_out = 16'h0000;
      end
   end
endmodule

/* tb/sas_seq_props.sv */
`timescale 1ns/1ps
`include "sas_params.svh"
// ****
// port checker
// ****
module sas_seq_props (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic [3:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic timer_a_event_in,
   input wire logic dma_ack_in,
   input wire logic [15:0] rdata_out,
   input wire logic irq_out,
   input wire logic sample_out,
   input wire logic [3:0] hold_enable_out,
   input wire logic [3:0] input_select_out,
   input wire logic convert_out,
   input wire sas_pkg::sas_dma_type dma_out
);
   logic [15:0] c1;
   logic [15:0] c2;
   logic msk;
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (rst_in);
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         c1 <= 16'h0000;
         c2 <= 16'h0000;
         msk <= 1'b0;
      end else if (wr_in) begin
         if (addr_in == `SAS_ADDR_CON1) c1 <= wdata_in;
         if (addr_in == `SAS_ADDR_CON2) c2 <= wdata_in;
         if (addr_in == `SAS_ADDR_MASK) msk <= wdata_in[0];
      end
   end
   sequence conv_run;
      convert_out [*8];
   endsequence
   sequence timer_end;
      sample_out && timer_a_event_in && c1[15] && c1[7:5] == 3'h2;
   endsequence
   sequence con1_read;
      $past(rd_in) && $past(addr_in) == `SAS_ADDR_CON1;
   endsequence
   chk_state_mutex: assert property (!(sample_out && convert_out))
      else $error("sample and convert high together");
   chk_conv_length: assert property ($rose(convert_out) |-> conv_run)
      else $error("conversion cut short");
   chk_sample_first: assert property ($rose(convert_out) |-> $past(sample_out))
      else $error("conversion without sampling");
   chk_timer_ends: assert property (timer_end |-> ##[1:3] convert_out)
      else $error("timer event did not start conversion");
   chk_par_hidden: assert property (con1_read and c1[10] |-> !rdata_out[3])
      else $error("parallel hold readable in 12-bit mode");
   chk_all_hold: assert property (sample_out && $past(sample_out) && c1[3]
      && !c1[10] && c2[9] |-> hold_enable_out == 4'hF)
      else $error("four channels not sampled together");
   chk_input_range: assert property (input_select_out <= 4'hC)
      else $error("input select beyond last input");
   chk_auto_restart: assert property ($fell(convert_out) && c1[15] && c1[2]
      |-> ##[0:3] sample_out)
      else $error("sampling not restarted");
   chk_irq_masked: assert property (!msk && !$past(msk) |-> !irq_out)
      else $error("masked interrupt raised");
   chk_dma_holds: assert property (dma_out.valid && !dma_ack_in
      |=> dma_out.valid)
      else $error("dma request dropped unacknowledged");
endmodule
bind sas_sequencer sas_seq_props u_props (.core_clk_in, .rst_in, .addr_in,
   .wdata_in, .wr_in, .rd_in, .timer_a_event_in, .dma_ack_in, .rdata_out,
   .irq_out, .sample_out, .hold_enable_out, .input_select_out, .convert_out,
   .dma_out);

/* tb/sas_dma_model.sv */
`timescale 1ns/1ps
// ****
// dma channel model
// ****
module sas_dma_model (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic slow_in,
   input wire sas_pkg::sas_dma_type dma_in,
   output logic ack_out,
   output logic [15:0] data_out,
   output logic [10:0] addr_out,
   output int count_out
);
   int wait_cnt;
   always_ff @(posedge core_clk_in) begin
      ack_out <= 1'b0;
      if (rst_in) begin
         wait_cnt <= 0;
         count_out <= 0;
      end else if (dma_in.valid && !ack_out) begin
         if (wait_cnt >= (slow_in ? 5 : 0)) begin
            ack_out <= 1'b1;
            data_out <= dma_in.data;
            addr_out <= dma_in.addr;
            count_out <= count_out + 1;
            wait_cnt <= 0;
         end else begin
            wait_cnt <= wait_cnt + 1;
         end
      end
   end
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
`include "sas_params.svh"
// ****
// sequencer bench
// ****
module tb_top;
   logic core_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [3:0] addr_in = 4'h0;
   logic [15:0] wdata_in = 16'h0000;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic timer_a_event_in = 1'b0;
   logic timer_b_event_in = 1'b0;
   logic [11:0] analog_result_in = 12'h000;
   logic slow = 1'b0;
   logic conv_d = 1'b0;
   logic dma_ack_in, irq_out, sample_out, convert_out;
   logic [3:0] hold_enable_out, input_select_out;
   logic [15:0] rdata_out, dma_data, rv, c1;
   logic [10:0] dma_addr;
   sas_pkg::sas_dma_type dma_out;
   int n_errors = 0, comparisons = 0, cycles = 0, n_conv = 0;
   int seed = 54077, dma_count, i, j, k, r, s, w, base;
   sas_sequencer dut (.core_clk_in, .rst_in, .addr_in, .wdata_in, .wr_in,
      .rd_in, .timer_a_event_in, .timer_b_event_in, .analog_result_in,
      .dma_ack_in, .rdata_out, .irq_out, .sample_out, .hold_enable_out,
      .input_select_out, .convert_out, .dma_out);
   sas_dma_model partner (.core_clk_in, .rst_in, .slow_in(slow),
      .dma_in(dma_out), .ack_out(dma_ack_in), .data_out(dma_data),
      .addr_out(dma_addr), .count_out(dma_count));
   always #10 core_clk_in = ~core_clk_in;
   always @(posedge core_clk_in) begin
      cycles <= cycles + 1;
      conv_d <= convert_out;
      if (conv_d && !convert_out) n_conv <= n_conv + 1;
      if (cycles == 30000) begin
         n_errors++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [15:0] seen,
      input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tick();
      @(posedge core_clk_in);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge core_clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge core_clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge core_clk_in);
      rd_in <= 1'b0;
      #1 d = rdata_out;
   endtask
   function automatic logic [15:0] fmt(input logic [1:0] f, input logic r12,
      input logic [11:0] a);
      logic [15:0] v;
      logic [11:0] b;
      b = r12 ? {~a[11], a[10:0]} : {2'h0, ~a[9], a[8:0]};
      v = r12 ? {4'h0, a} : {6'h00, a[9:0]};
      if (f == 2'h3) v = r12 ? {b, 4'h0} : {b[9:0], 6'h00};
      else if (f == 2'h2) v = r12 ? {a, 4'h0} : {a[9:0], 6'h00};
      else if (f == 2'h1) v = r12 ? {{4{b[11]}}, b} : {{6{b[9]}}, b[9:0]};
      return v;
   endfunction
   initial begin
      repeat (4) @(posedge core_clk_in);
      rst_in <= 1'b0;
      rd(`SAS_ADDR_CON1, rv);
      check("con1 reset", rv, 16'h0000);
      for (i = 0; i < 8; i++) begin
         r = $random(seed);
         rv = r[15:0] & 16'h7FFC;
         wr(`SAS_ADDR_CON1, rv); // converter kept off
         wr(4'h9, r[31:16]);
         rv = rv & `SAS_C1_WMASK & ~{12'h000, rv[10], 3'h0};
         rd(`SAS_ADDR_CON1, c1);
         check("con1 fields", c1, rv);
      end
      for (i = 0; i < 6; i++) begin
         r = $random(seed);
         k = r[19:16] % 13;
         s = r[21:20];
         analog_result_in <= r[11:0];
         slow <= i[0];
         wr(`SAS_ADDR_CON1, 16'h0000); // off before resolution change
         wr(`SAS_ADDR_CHS0, 16'(k));
         wr(`SAS_ADDR_CON4, 16'h0000);
         wr(`SAS_ADDR_CON2, {12'h000, r[21:20], 2'b00});
         wr(`SAS_ADDR_MASK, 16'h0001);
         c1 = {3'h0, i[0], 1'b0, i >= 3, 2'(3 - i % 3), 8'hE4};
         wr(`SAS_ADDR_CON1, c1);
         wr(`SAS_ADDR_CON1, c1 | 16'h8000); // enable last
         wr(`SAS_ADDR_STAT, 16'h0001); // then clear flag
         base = n_conv;
         w = dma_count;
         for (j = 0; j < 2000 && irq_out !== 1'b1; j++) tick();
         tick();
         check("ops per irq", 16'(n_conv - base), 16'(s + 1));
         for (j = 0; j < 50 && dma_count == w; j++) tick();
         check("dma count", 16'(dma_count - w), 16'h0001);
         check("dma data", dma_data, fmt(c1[9:8], c1[10], r[11:0]));
         check("dma addr", {5'h00, dma_addr}, 16'(i[0] ? s : k));
         wr(`SAS_ADDR_CON1, c1);
         wr(`SAS_ADDR_MASK, 16'h0000);
         rd(`SAS_ADDR_STAT, rv);
         check("irq status", rv, 16'h0001);
         check("irq masked", {15'h0000, irq_out}, 16'h0000);
         wr(`SAS_ADDR_STAT, 16'h0001);
         rd(`SAS_ADDR_STAT, rv);
         check("irq cleared", rv, 16'h0000);
      end
      wr(`SAS_ADDR_CON2, 16'h0000);
      wr(`SAS_ADDR_CON1, 16'h8000);
      wr(`SAS_ADDR_CON1, 16'h8002);
      rd(`SAS_ADDR_CON1, rv);
      check("acq set", rv & 16'h0003, 16'h0002);
      wr(`SAS_ADDR_CON1, 16'h8000);
      for (j = 0; j < 40 && rv[0] !== 1'b1; j++) rd(`SAS_ADDR_CON1, rv);
      check("done no restart", rv & 16'h0003, 16'h0001);
      wr(`SAS_ADDR_CON1, 16'h8003);
      rd(`SAS_ADDR_CON1, rv);
      check("done write one", rv & 16'h0003, 16'h0003);
      wr(`SAS_ADDR_CON1, 16'h8001);
      rd(`SAS_ADDR_CON1, rv);
      check("done at start", rv & 16'h0001, 16'h0000);
      for (i = 0; i < 2; i++) begin
         wr(`SAS_ADDR_CON1, 16'h0000);
         wr(`SAS_ADDR_CON2, i ? 16'h0200 : 16'h0100);
         wr(`SAS_ADDR_CON1, i ? 16'h808C : 16'h804C);
         repeat (30) tick();
         check("no early convert", {15'h0000, convert_out}, 16'h0000);
         check("hold group", {12'h000, hold_enable_out},
            i ? 16'h000F : 16'h0003);
         @(posedge core_clk_in);
         timer_a_event_in <= !i[0];
         timer_b_event_in <= i[0];
         @(posedge core_clk_in);
         timer_a_event_in <= 1'b0;
         timer_b_event_in <= 1'b0;
         for (j = 0; j < 5 && convert_out !== 1'b1; j++) tick();
         check("timer convert", {15'h0000, convert_out}, 16'h0001);
      end
      print_verdict();
   end
endmodule
